// File: hw/spf_pkg.sv
// constants of the spi flag, error and transmit queue block
// What this block does
// - mode fault flag sets only when enabled
// - disabling enable keeps flag; no re-set
// - rx, overrun, fault share one error request
// - master with select low sets mode fault
// - master fault: irq, disable, tx empty, reset
// - mode fault leaves master select unchanged
// - slave select rising mid-transfer sets fault
// - slave start depends on phase; ends idle
// - phase 0 select/deselect faults without clocks
// - slave fault keeps port enabled and running
// - deselected slave floats output, ignores clocks
// - status read then control write clears fault
// - tx request when empty and enabled
// - rx request needs enable and port enable
// - completed byte sets receiver full
// - load sets tx empty; write clears it
// - master sends queued byte straight after previous
// - slave with no new byte resends shift register
// - idle tx empty returns within two cycles
// - status then data read clears rx full
// - overrun drops bytes; read sequence clears it
// - unread byte at first bit sets overrun
// - port disabled resets transfer, sets tx empty, keeps other flags
package spf_pkg;
  localparam int unsigned SPF_BITS     = 8;          // bits per transfer
  localparam int unsigned SPF_CLK_NS   = 10;         // bus clock period
  localparam int unsigned SPF_HALF_NS  = 40;         // master serial half period
  localparam int unsigned SPF_HALF_CYC = SPF_HALF_NS / SPF_CLK_NS;
  localparam logic [7:0]  SPF_DIV_LOAD = 8'(SPF_HALF_CYC - 1);
  localparam logic [7:0]  SPF_RST_BYTE = 8'h00;      // data reset value
  localparam logic [3:0]  SPF_RST_CNT  = 4'h0;       // bit counter reset
  localparam logic [3:0]  SPF_LAST_BIT = 4'h7;       // count before eighth
  localparam logic [3:0]  SPF_PIN_RST  = 4'h2;       // sync stages reset, select high
  localparam int unsigned SPF_P_SCK    = 0;          // sync vector bit positions
  localparam int unsigned SPF_P_SS     = 1;
  localparam int unsigned SPF_P_MISO   = 2;
  localparam int unsigned SPF_P_MOSI   = 3;
endpackage

// File: hw/spf_core.sv
// spi flag, error, interrupt and double-buffered transmit logic
`timescale 1ns/1ps
`default_nettype none
module spf_core (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // cpu access strobes
  input  wire logic       status_read,
  input  wire logic       data_read,
  input  wire logic       data_write,
  input  wire logic [7:0] wr_data,
  output logic            wr_ready,
  input  wire logic       control_write,
  input  wire logic       ctl_port_enable,
  input  wire logic       ctl_master_select,
  input  wire logic       ctl_cpol,
  input  wire logic       ctl_cpha,
  // configuration levels
  input  wire logic       mode_fault_enable,
  input  wire logic       error_irq_enable,
  input  wire logic       tx_irq_enable,
  input  wire logic       rx_irq_enable,
  // status
  output logic            port_enable,
  output logic            master_select,
  output logic            clock_phase,
  output logic            clock_polarity,
  output logic            rx_full_flag,
  output logic            tx_empty_flag,
  output logic            overrun_flag,
  output logic            mode_fault_flag,
  output logic [7:0]      rx_data,
  output logic            rd_valid,
  // interrupt requests
  output logic            tx_irq,
  output logic            rx_err_irq,
  // serial pins
  input  wire logic       serial_clock_pin_in,
  output logic            serial_clock_pin_out,
  output logic            serial_clock_pin_oe,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic       ss_n_in
);
  import spf_pkg::*;
  localparam int TXE_MAX = 2;   // tx empty return bound
  // pin synchronisers and edge history
  logic [3:0] sync1;            // first stage, read only by sync2
  logic [3:0] sync2;            // second stage
  logic       sck_prev;         // last synced serial clock
  logic       ss_prev;          // last synced select

  // core state
  logic       active;           // transfer in progress
  logic [3:0] bit_cnt;          // completed bit shifts
  logic [7:0] shifter;          // shift register
  logic [7:0] tx_reg;           // transmit data register
  logic       in_bit;           // bit sampled on leading edge
  logic       drop;             // byte of this transfer is lost
  logic [7:0] div;              // master half period divider
  logic       m_wait;           // phase 0 initial idle half
  logic       m_lvl;            // master clock in active level
  logic       rx_arm;           // status read saw rx full
  logic       ov_arm;           // status read saw overrun
  logic       mf_arm;           // status read saw mode fault
  logic       next_active, next_drop, next_in_bit, next_m_wait, next_m_lvl;
  logic       next_pe, next_ms, next_cpol, next_cpha;
  logic       next_rxf, next_txe, next_ovr, next_mf;
  logic       next_rx_arm, next_ov_arm, next_mf_arm;
  logic [3:0] next_bit_cnt;
  logic [7:0] next_shifter, next_tx_reg, next_rx_data, next_div;
  // decoded events
  logic ss_high, ss_rose, ss_fell, slave, s_lead, s_trail, tick;
  logic lead, trail, din, samp, load, start, m_fault, s_fault;
  logic [7:0] shifted;
  // two flops on every pin input
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1    <= SPF_PIN_RST;
      sync2    <= SPF_PIN_RST;
      sck_prev <= 1'b0;
      ss_prev  <= 1'b1;
    end else if (ce) begin
      sync1    <= {mosi_in, miso_in, ss_n_in, serial_clock_pin_in};
      sync2    <= sync1;
      sck_prev <= sync2[SPF_P_SCK];
      ss_prev  <= sync2[SPF_P_SS];
    end
  end
  // edge and condition decode
  always_comb begin
    ss_high = sync2[SPF_P_SS];
    ss_rose = ss_high & ~ss_prev;
    ss_fell = ~ss_high & ss_prev;
    slave   = port_enable & ~master_select;
    // deselected slave ignores every clock edge
    s_lead  = slave & ~ss_high & (sck_prev == clock_polarity) &
              (sync2[SPF_P_SCK] != clock_polarity);
    s_trail = slave & ~ss_high & (sck_prev != clock_polarity) &
              (sync2[SPF_P_SCK] == clock_polarity);
    tick    = port_enable & master_select & active & (div == 8'h00);
    lead    = s_lead | (tick & ~m_wait & ~m_lvl);
    trail   = s_trail | (tick & ~m_wait & m_lvl);
    din     = master_select ? sync2[SPF_P_MISO] : sync2[SPF_P_MOSI];
    samp    = active & (clock_phase ? trail : lead);
    shifted = {shifter[6:0], clock_phase ? din : in_bit};
    // queued byte moves to the shifter whenever idle
    load    = port_enable & ~active & ~tx_empty_flag;
    // slave phase 0 starts on select fall, phase 1 on first clock edge; master on load
    start   = (load & master_select) |
              (slave & ~active & (clock_phase ? s_lead : ss_fell));
    m_fault = mode_fault_enable & port_enable & master_select & ~ss_high;
    s_fault = mode_fault_enable & slave & active & ss_rose;
  end
  // next state of the transfer engine and flags
  always_comb begin
    next_active  = active;
    next_bit_cnt = bit_cnt;
    next_shifter = shifter;
    next_tx_reg  = tx_reg;
    next_rx_data = rx_data;
    next_in_bit  = in_bit;
    next_drop    = drop;
    next_div     = div;
    next_m_wait  = m_wait;
    next_m_lvl   = m_lvl;
    next_pe      = port_enable;
    next_ms      = master_select;
    next_cpol    = clock_polarity;
    next_cpha    = clock_phase;
    next_rxf     = rx_full_flag;
    next_txe     = tx_empty_flag;
    next_ovr     = overrun_flag;
    next_mf      = mode_fault_flag;
    next_rx_arm  = rx_arm;
    next_ov_arm  = ov_arm;
    next_mf_arm  = mf_arm;
    // control register write; clears an armed mode fault
    if (control_write) begin
      next_pe   = ctl_port_enable;
      next_ms   = ctl_master_select;
      next_cpol = ctl_cpol;
      next_cpha = ctl_cpha;
      if (mf_arm & ~m_fault & ~s_fault) next_mf = 1'b0;
      next_mf_arm = 1'b0;
    end
    // status read arms each flag's clear
    if (status_read) begin
      next_rx_arm = rx_full_flag;
      next_ov_arm = overrun_flag;
      next_mf_arm = mode_fault_flag;
    end
    // data read finishes armed rx full and overrun clears
    if (data_read) begin
      if (rx_arm) next_rxf = 1'b0;
      if (ov_arm) next_ovr = 1'b0;
      next_rx_arm = 1'b0;
      next_ov_arm = 1'b0;
    end
    // a write is accepted only while the buffer is empty
    if (data_write & tx_empty_flag) begin
      next_tx_reg = wr_data;
      next_txe    = 1'b0;
    end
    // master clock divider
    if (active & master_select) begin
      next_div = (div == 8'h00) ? SPF_DIV_LOAD : div - 8'h01;
    end else begin
      next_div = SPF_DIV_LOAD;
    end
    if (tick) begin
      next_m_wait = 1'b0;
      if (~m_wait) begin
        next_m_lvl = ~m_lvl;
      end
    end
    // buffer to shifter; without a new byte a slave resends the shift register contents
    if (load) begin
      next_shifter = tx_reg;
      next_txe     = 1'b1;
    end
    if (start) begin
      next_active  = 1'b1;
      next_bit_cnt = SPF_RST_CNT;
      next_drop    = 1'b0;
      next_m_wait  = ~clock_phase;
      next_m_lvl   = 1'b0;
      next_div     = SPF_DIV_LOAD;
    end
    if (active & lead & ~clock_phase) next_in_bit = din;
    // unread byte at the first capture: this byte is lost
    if (samp & (bit_cnt == SPF_RST_CNT) & (rx_full_flag | overrun_flag)) begin
      next_drop = 1'b1;
      next_ovr  = rx_full_flag | overrun_flag;
    end
    // shift on every trailing edge, finish after the eighth
    if (active & trail) begin
      next_shifter = shifted;
      next_bit_cnt = bit_cnt + 4'h1;
      if (bit_cnt == SPF_LAST_BIT) begin
        next_active = 1'b0;
        if (~drop & ~overrun_flag) begin
          next_rx_data = shifted;
          next_rxf     = 1'b1;
        end
      end
    end
    // slave fault only flags; enable and transfer stay
    if (s_fault) begin
      next_mf     = 1'b1;
      next_mf_arm = 1'b0;
    end
    // master fault stops the port and frees the pins
    if (m_fault) begin
      next_mf      = 1'b1;
      next_mf_arm  = 1'b0;
      next_pe      = 1'b0;
      next_txe     = 1'b1;
      next_active  = 1'b0;
      next_bit_cnt = SPF_RST_CNT;
    end
    // disabled port: partial reset, tx empty set, other flags and controls kept
    if (~port_enable) begin
      next_txe     = 1'b1;
      next_active  = 1'b0;
      next_shifter = SPF_RST_BYTE;
      next_bit_cnt = SPF_RST_CNT;
    end
  end

  // state registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active          <= 1'b0;
      bit_cnt         <= SPF_RST_CNT;
      shifter         <= SPF_RST_BYTE;
      tx_reg          <= SPF_RST_BYTE;
      rx_data         <= SPF_RST_BYTE;
      in_bit          <= 1'b0;
      drop            <= 1'b0;
      div             <= SPF_DIV_LOAD;
      m_wait          <= 1'b0;
      m_lvl           <= 1'b0;
      port_enable     <= 1'b0;
      master_select   <= 1'b0;
      clock_polarity  <= 1'b0;
      clock_phase     <= 1'b0;
      rx_full_flag    <= 1'b0;
      tx_empty_flag   <= 1'b1;
      overrun_flag    <= 1'b0;
      mode_fault_flag <= 1'b0;
      rx_arm          <= 1'b0;
      ov_arm          <= 1'b0;
      mf_arm          <= 1'b0;
    end else if (ce) begin
      active          <= next_active;
      bit_cnt         <= next_bit_cnt;
      shifter         <= next_shifter;
      tx_reg          <= next_tx_reg;
      rx_data         <= next_rx_data;
      in_bit          <= next_in_bit;
      drop            <= next_drop;
      div             <= next_div;
      m_wait          <= next_m_wait;
      m_lvl           <= next_m_lvl;
      port_enable     <= next_pe;
      master_select   <= next_ms;
      clock_polarity  <= next_cpol;
      clock_phase     <= next_cpha;
      rx_full_flag    <= next_rxf;
      tx_empty_flag   <= next_txe;
      overrun_flag    <= next_ovr;
      mode_fault_flag <= next_mf;
      rx_arm          <= next_rx_arm;
      ov_arm          <= next_ov_arm;
      mf_arm          <= next_mf_arm;
    end
  end

  // handshakes, interrupt requests and pins
  always_comb begin
    wr_ready   = tx_empty_flag;
    rd_valid   = rx_full_flag;
    tx_irq     = tx_empty_flag & tx_irq_enable;
    rx_err_irq = (rx_full_flag & rx_irq_enable & port_enable) |
                 (error_irq_enable & (overrun_flag | mode_fault_flag));
    serial_clock_pin_out = clock_polarity ^ m_lvl;
    serial_clock_pin_oe  = port_enable & master_select;
    mosi_out = shifter[7];
    mosi_oe  = port_enable & master_select;
    miso_out = shifter[7];
    miso_oe  = slave & ~ss_high;
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);
  a_fault_needs_en: assert property ($rose(mode_fault_flag) |-> $past(mode_fault_enable))
    else $error("mode fault set while its enable was clear");
  a_master_fault_act: assert property (m_fault |=> mode_fault_flag && !port_enable &&
      tx_empty_flag && !active && bit_cnt == 4'h0 && !mosi_oe)
    else $error("master mode fault did not stop the port");
  a_fault_keeps_ms: assert property ($rose(mode_fault_flag) && !$past(control_write)
      |-> master_select == $past(master_select))
    else $error("mode fault changed master select");
  a_slave_fault_run: assert property (s_fault && !control_write
      |=> mode_fault_flag && port_enable)
    else $error("slave mode fault disabled the port");
  a_ss_high_float: assert property (ss_high && !master_select |-> !miso_oe)
    else $error("deselected slave drives its output");
  a_txe_return: assert property (load ##1 !data_write [*1] |-> ##[0:TXE_MAX] tx_empty_flag)
    else $error("tx empty not back in time");
  a_overrun_keeps: assert property ($rose(overrun_flag) |-> $stable(rx_data)
      ##1 (rx_data == $past(rx_data)))
    else $error("overrun replaced the unread byte");
  a_no_rxf_on_ovr: assert property ($rose(rx_full_flag) |-> !$past(overrun_flag))
    else $error("receiver full set during overrun");
  a_disable_reset: assert property (!port_enable |=> tx_empty_flag && !active &&
      shifter == 8'h00)
    else $error("disabled port kept transfer state");
  a_tx_irq: assert property (tx_empty_flag && tx_irq_enable |-> tx_irq)
    else $error("transmit request missing");
  a_fault_clear: assert property (control_write && mf_arm && !m_fault && !s_fault
      |=> !mode_fault_flag)
    else $error("armed mode fault not cleared");
  c_master_byte: cover property (master_select && active ##1 $rose(rx_full_flag));
  c_slave_fault: cover property (s_fault);
  c_overrun:     cover property ($rose(overrun_flag));
  c_queued_pair: cover property (load && master_select ##[1:300] load);
endmodule
`default_nettype wire

// File: bench/spf_far.sv
// remote spi device: slave to a master block, master to a slave block
`timescale 1ns/1ps
`default_nettype none
module spf_far (
  // role select, high acts as master
  input  wire logic role_m,
  // resolved lines
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic miso,
  // lines driven by this model
  output logic      p_sck,
  output logic      p_mosi,
  output logic      p_miso,
  output logic      p_ss_n
);
  logic [7:0] tx = 8'h00;  // outgoing shifter
  logic [7:0] rx = 8'h00;  // last captured byte
  logic [7:0] nxt = 8'h00; // byte for the following frame
  int         cnt = 0;     // trailing edges seen
  assign p_miso = tx[7];
  initial begin
    p_sck = 1'b0;
    p_mosi = 1'b0;
    p_ss_n = 1'b1;
  end
  // slave role samples on leading edge, msb first
  always @(posedge sck) if (!role_m) rx <= {rx[6:0], mosi};
  // slave role shifts on trailing edge, reloads after eight bits
  always @(negedge sck) if (!role_m) begin
    cnt = cnt + 1;
    if (cnt == 8) begin
      tx <= nxt;
      cnt = 0;
    end else tx <= tx << 1;
  end
  // preset the first outgoing byte
  task automatic load(input logic [7:0] b);
    tx = b;
    cnt = 0;
  endtask
  // one phase 0 frame as master, clock still outside it
  task automatic xfer(input logic [7:0] b);
    tx = b;
    p_ss_n = 1'b0;
    #125;
    for (int i = 0; i < 8; i++) begin
      p_mosi = tx[7];
      #62.5 p_sck = 1'b1;
      rx = {rx[6:0], miso};
      #62.5 p_sck = 1'b0;
      tx = tx << 1;
    end
    #250 p_ss_n = 1'b1;
    p_mosi = ~p_mosi;
  endtask
endmodule
`default_nettype wire

// File: bench/spi_flags_errors_queuing_bench.sv
// self-checking bench of the spi flag, error and queue block
`timescale 1ns/1ps
`default_nettype none
module spi_flags_errors_queuing_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sr = 1'b0, dr = 1'b0, dw = 1'b0, cw = 1'b0;  // cpu strobes
  logic c_pe = 1'b0, c_ms = 1'b0, c_pha = 1'b0;       // control fields
  logic mfe = 1'b0, eie = 1'b0, tie = 1'b0, rie = 1'b0;
  logic ss_b = 1'b1;                                   // bench select pull
  logic far_m = 1'b0;                                  // far side is master
  logic [7:0] wd = 8'h00;
  logic wr_ready, pe, ms, cph, cpo, rxf, txe, ovr, mf, rdv, tx_irq, rxe_irq;
  logic [7:0] rx_data;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic p_sck, p_mosi, p_miso, p_ss_n;
  logic [31:0] seed = 32'h40;
  logic [7:0] exp_q[$];   // expected received bytes
  logic [7:0] a, b, p2, s;
  logic rf_q = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  // wire resolution from the dut output enables; select lines anded
  wire sck_w = sck_oe ? sck_o : p_sck;
  wire mosi_w = mosi_oe ? mosi_o : p_mosi;
  wire miso_w = miso_oe ? miso_o : p_miso;
  wire ss_w = p_ss_n & ss_b;
  spf_core dut_u (.clk(clk), .reset(reset), .ce(1'b1), .status_read(sr), .data_read(dr),
    .data_write(dw), .wr_data(wd), .wr_ready(wr_ready), .control_write(cw),
    .ctl_port_enable(c_pe), .ctl_master_select(c_ms), .ctl_cpol(1'b0), .ctl_cpha(c_pha),
    .mode_fault_enable(mfe), .error_irq_enable(eie), .tx_irq_enable(tie),
    .rx_irq_enable(rie), .port_enable(pe), .master_select(ms), .clock_phase(cph),
    .clock_polarity(cpo), .rx_full_flag(rxf), .tx_empty_flag(txe), .overrun_flag(ovr),
    .mode_fault_flag(mf), .rx_data(rx_data), .rd_valid(rdv), .tx_irq(tx_irq),
    .rx_err_irq(rxe_irq), .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
    .serial_clock_pin_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_o), .miso_oe(miso_oe), .ss_n_in(ss_w));
  spf_far far_u (.role_m(far_m), .sck(sck_w), .mosi(mosi_w), .miso(miso_w),
    .p_sck(p_sck), .p_mosi(p_mosi), .p_miso(p_miso), .p_ss_n(p_ss_n));
  // bus clock
  initial begin
    forever #5 clk = ~clk;
  end
  // xorshift values
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic strobe(ref logic st);
    st = 1'b1;
    tick(1);
    st = 1'b0;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ctl(input logic pe_v, input logic ms_v, input logic ph_v);
    c_pe = pe_v;
    c_ms = ms_v;
    c_pha = ph_v;
    strobe(cw);
  endtask
  task automatic wait_rx();
    for (int i = 0; i < 3000 && rxf !== 1'b1; i++) tick(1);
  endtask
  task automatic wr(input logic [7:0] v);
    for (int i = 0; i < 3000 && txe !== 1'b1; i++) tick(1);
    wd = v;
    strobe(dw);
  endtask
  task automatic rd();
    strobe(sr);
    strobe(dr);
  endtask
  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watcher: each new receiver-full takes the oldest expected byte
  always @(posedge clk) begin
    if (rxf === 1'b1 && rf_q !== 1'b1 && exp_q.size() > 0) check(rx_data, exp_q.pop_front());
    rf_q <= rxf;
  end
  // watchdog
  initial begin
    #300000;
    error_cnt++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    tick(1);
    check(txe, 1'b1);
    check(mf, 1'b0);
    // master, two queued bytes then an overrun
    ctl(1'b1, 1'b1, 1'b0);
    a = rnd();
    b = rnd();
    far_u.load(rnd());
    exp_q.push_back(far_u.tx);
    p2 = rnd();
    far_u.nxt = p2;
    exp_q.push_back(p2);
    wr(a);
    check(txe, 1'b0);
    check(wr_ready, 1'b0);
    tick(1);
    check(txe, 1'b1);
    wr(b);
    check(txe, 1'b0);
    wait_rx();
    check(far_u.rx, a);
    check(rdv, 1'b1);
    far_u.nxt = rnd();
    rd();
    check(rxf, 1'b0);
    wait_rx();
    check(far_u.rx, b);
    check(txe, 1'b1);
    eie = 1'b1;
    wr(rnd());
    tick(150);
    check(ovr, 1'b1);
    check(rx_data, p2);
    check(rxe_irq, 1'b1);
    rd();
    check(ovr, 1'b0);
    check(rxf, 1'b0);
    // master mode fault
    ss_b = 1'b0;
    tick(8);
    check(mf, 1'b0);
    ss_b = 1'b1;
    tick(8);
    mfe = 1'b1;
    ss_b = 1'b0;
    tick(8);
    check(mf, 1'b1);
    check(pe, 1'b0);
    check(txe, 1'b1);
    check(ms, 1'b1);
    check(rxe_irq, 1'b1);
    check(sck_oe, 1'b0);
    check(mosi_oe, 1'b0);
    tie = 1'b1;
    tick(1);
    check(tx_irq, 1'b1);
    mfe = 1'b0;
    tick(2);
    check(mf, 1'b1);
    ss_b = 1'b1;
    tick(6);
    strobe(sr);
    ctl(1'b1, 1'b0, 1'b0);
    check(mf, 1'b0);
    // slave frame driven by the far master
    eie = 1'b0;
    rie = 1'b1;
    mfe = 1'b1;
    far_m = 1'b1;
    s = rnd();
    wr(s);
    tick(2);
    exp_q.push_back(rnd());
    far_u.xfer(exp_q[0]);
    tick(3);
    wait_rx();
    check(far_u.rx, s);
    check(mf, 1'b0);
    check(rxe_irq, 1'b1);
    check(miso_oe, 1'b0);
    rd();
    // select then deselect without clocks, phase 0 then phase 1
    ss_b = 1'b0;
    tick(10);
    ss_b = 1'b1;
    tick(8);
    check(mf, 1'b1);
    check(pe, 1'b1);
    strobe(sr);
    ctl(1'b0, 1'b0, 1'b1);
    check(mf, 1'b0);
    tick(1);
    ctl(1'b1, 1'b0, 1'b1);
    check(pe, 1'b1);
    check(cph, 1'b1);
    ss_b = 1'b0;
    tick(10);
    ss_b = 1'b1;
    tick(8);
    check(mf, 1'b0);
    ctl(1'b0, 1'b0, 1'b1);
    tick(2);
    check(txe, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
